// file: esr_chk.sv
// Purpose: port-level checks of the event status block
// Assumes: one clock, asynchronous active-low reset
// Notes:   enables are internal, so checks lean on read answers and pulses
`timescale 1ns/1ps
module esr_chk (
  input wire logic                 sys_clk,
  input wire logic                 rstn,
  input wire esr_pkg::esr_sel_type acc_sel,
  input wire logic                 acc_rd,
  input wire logic [7:0]           acc_rdata,
  input wire logic                 acc_rvalid,
  input wire logic                 syntax_fault,
  input wire logic                 reply_fault,
  input wire logic                 ignore_to_terminator,
  input wire logic                 queue_flush,
  input wire logic                 master_summary,
  input wire logic                 service_request
);
  import esr_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence rd_ans_s; acc_rd ##1 acc_rvalid; endsequence
  sequence rd_of_s(esr_sel_type s); acc_rvalid && $past(acc_sel) == s; endsequence
  chk_read_answer: assert property (acc_rd |-> rd_ans_s) else $error("read not answered");
  chk_answer_cause: assert property (acc_rvalid |-> $past(acc_rd))
    else $error("answer without read");
  chk_syntax_ignore: assert property (syntax_fault |=> ignore_to_terminator)
    else $error("ignore flag missing");
  chk_ignore_cause: assert property (ignore_to_terminator |-> $past(syntax_fault))
    else $error("ignore flag without cause");
  chk_reply_flush: assert property (reply_fault |=> queue_flush)
    else $error("queue flush missing");
  chk_flush_cause: assert property (queue_flush |-> $past(reply_fault))
    else $error("queue flush without cause");
  chk_std_unused: assert property (rd_of_s(ESR_SEL_STD_EVT) |->
    (acc_rdata & STD_UNUSED_MASK) == 8'h00) else $error("unused bit set");
  chk_unit1_and: assert property (rd_of_s(ESR_SEL_UNIT1) ##0 acc_rdata[6] |->
    acc_rdata[1] && acc_rdata[4]) else $error("and bit without both");
  chk_master_request: assert property ($rose(master_summary) |-> service_request)
    else $error("request missing");
endmodule : esr_chk
bind esr_status esr_chk esr_chk_inst (.sys_clk(sys_clk), .rstn(rstn), .acc_sel(acc_sel),
  .acc_rd(acc_rd), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid),
  .syntax_fault(syntax_fault), .reply_fault(reply_fault),
  .ignore_to_terminator(ignore_to_terminator), .queue_flush(queue_flush),
  .master_summary(master_summary), .service_request(service_request));

// file: esr_ctl_model.sv
// Purpose: remote controller model issuing queries, settings and clear-status
// Assumes: called at a falling edge; request taken at the next rising edge
// Notes:   idle select and data show the inverse so stale values are never trusted
`timescale 1ns/1ps
module esr_ctl_model (
  input wire logic            sys_clk,
  output esr_pkg::esr_sel_type acc_sel,
  output logic                acc_rd,
  output logic                acc_wr,
  output logic [7:0]          acc_wdata,
  output logic                clear_status,
  input wire logic [7:0]      acc_rdata,
  input wire logic            acc_rvalid
);
  import esr_pkg::*;
  initial begin
    {acc_rd, acc_wr, clear_status, acc_wdata} = '0;
    acc_sel = ESR_SEL_STB;
  end
  task automatic rd(input esr_sel_type sel, output logic [7:0] data);
    int n = 0;
    acc_sel = sel;
    acc_rd  = 1'b1;
    @(negedge sys_clk);
    acc_rd  = 1'b0;
    acc_sel = esr_sel_type'(~sel);
    while (acc_rvalid !== 1'b1 && n < 4) begin
      @(negedge sys_clk);
      n++;
    end
    data = acc_rdata;
  endtask : rd
  task automatic wr(input esr_sel_type sel, input logic [7:0] data);
    acc_sel   = sel;
    acc_wdata = data;
    acc_wr    = 1'b1;
    @(negedge sys_clk);
    acc_wr    = 1'b0;
    acc_sel   = esr_sel_type'(~sel);
    acc_wdata = ~data;
  endtask : wr
  task automatic cls();
    clear_status = 1'b1;
    @(negedge sys_clk);
    clear_status = 1'b0;
  endtask : cls
endmodule : esr_ctl_model

// file: esr_evt_if.sv
// Purpose: carrier between the top and one sticky event register
// Assumes: single clock domain
// Notes:   set is a per-bit pulse, clear and write enable are one-cycle strobes
`timescale 1ns/1ps
interface esr_evt_if;
  logic [7:0] set;
  logic       clr;
  logic       wr_en;
  logic [7:0] wr_data;
  logic [7:0] status;
  logic [7:0] enable;
  logic       summary;

  modport reg_side (
    input  set,
    input  clr,
    input  wr_en,
    input  wr_data,
    output status,
    output enable,
    output summary
  );
  modport ctl_side (
    output set,
    output clr,
    output wr_en,
    output wr_data,
    input  status,
    input  enable,
    input  summary
  );
endinterface : esr_evt_if

// file: esr_evt_reg.sv
// Purpose: one sticky 8-bit event register with its enable mask and summary
// Assumes: set has priority over clear in the same cycle
// Notes:   reset value of the event bits is a parameter so power-up can preload a flag
`timescale 1ns/1ps
module esr_evt_reg #(
  parameter logic [7:0] EVT_RESET = 8'h00
) (
  input wire logic        sys_clk,
  input wire logic        rstn,
  esr_evt_if.reg_side     evt
);
  import esr_pkg::*;

  logic [7:0] status_q;
  logic [7:0] enable_q;
  logic       summary_q;

  // set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      status_q <= EVT_RESET;
    end else if (evt.clr) begin
      status_q <= evt.set;
    end else begin
      status_q <= status_q | evt.set;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      enable_q <= ESR_EN_RESET;
    end else if (evt.wr_en) begin
      enable_q <= evt.wr_data;
    end
  end

  // summary is registered; lags the status by one cycle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      summary_q <= 1'b0;
    end else begin
      summary_q <= |(status_q & enable_q);
    end
  end

  assign evt.status  = status_q;
  assign evt.enable  = enable_q;
  assign evt.summary = summary_q;

endmodule : esr_evt_reg

// file: esr_pkg.sv
// Purpose: constants and types shared by the event status reporting block
// Assumes: one 125 MHz clock, registers reached through a command-decoded access port
// Notes:   register selects stand in for the remote command set
package esr_pkg;

  localparam int unsigned ESR_WIDTH = 8;
  localparam int unsigned ESR_UNITS = 4;

  // register select codes on the access port
  typedef enum logic [3:0] {
    ESR_SEL_STB     = 4'h0,
    ESR_SEL_SRE     = 4'h1,
    ESR_SEL_STD_EVT = 4'h2,
    ESR_SEL_STD_EN  = 4'h3,
    ESR_SEL_UNIT0   = 4'h4,
    ESR_SEL_UNIT1   = 4'h5,
    ESR_SEL_UNIT2   = 4'h6,
    ESR_SEL_UNIT3   = 4'h7,
    ESR_SEL_UEN0    = 4'h8,
    ESR_SEL_UEN1    = 4'h9,
    ESR_SEL_UEN2    = 4'ha,
    ESR_SEL_UEN3    = 4'hb
  } esr_sel_type;

  // standard event bit positions
  localparam int unsigned STD_OPS_DONE     = 0;
  localparam int unsigned STD_CTRL_REQ     = 1;
  localparam int unsigned STD_REPLY_FAULT  = 2;
  localparam int unsigned STD_DEVICE_FAULT = 3;
  localparam int unsigned STD_RUN_FAULT    = 4;
  localparam int unsigned STD_SYNTAX_FAULT = 5;
  localparam int unsigned STD_USER_REQ     = 6;
  localparam int unsigned STD_POWER_UP     = 7;

  // bits the device never sets
  localparam logic [7:0] STD_UNUSED_MASK = 8'h42;

  // status byte bit positions
  localparam int unsigned STB_STD_SUMMARY = 5;
  localparam int unsigned STB_MSG_AVAIL   = 4;
  localparam int unsigned STB_MASTER      = 6;

  // unit event register 1 positions
  localparam int unsigned U1_PRIMARY_INSIDE   = 1;
  localparam int unsigned U1_SECONDARY_INSIDE = 4;
  localparam int unsigned U1_BOTH_INSIDE      = 6;

  // reset values
  localparam logic [7:0] ESR_EVT_RESET = 8'h00;
  localparam logic [7:0] ESR_EN_RESET  = 8'h00;
  localparam logic [7:0] ESR_STD_PWRUP = 8'h80;

endpackage : esr_pkg

// file: esr_status.sv
// Purpose: event status reporting: standard and four unit event registers, status byte
// Assumes: command parser decodes queries and settings into sel/rd/wr strobes
// Notes:   message-available comes from outside logic; service request output is made here
// How it works
// - standard event summary drives status byte bit 5
// - standard register clears on clear-status, query, power-up
// - power-up flag bit 7 set at power-up
// - bits 6 and 1 never set
// - syntax fault sets bit 5
// - run fault sets bit 4
// - device fault sets bit 3
// - reply fault sets bit 2, clears queue
// - operations done sets bit 0
// - enable mask bits gate the summary
// - four unit registers each with enable mask
// - unit register n summary sets status bit n
// - unit registers clear on clear-status, query, power-up
// - unit register 0 measurement event layout
// - unit register 1 comparator layout with AND bit
// - unit register 2 bins 1 to 8
// - unit register 3 bins 9-13, limits, outside
// - enabled status bit rising sets master and request
`timescale 1ns/1ps
module esr_status (
  input  wire logic                 sys_clk,
  input  wire logic                 rstn,
  // register access from the command decoder
  input  wire esr_pkg::esr_sel_type acc_sel,
  input  wire logic                 acc_rd,
  input  wire logic                 acc_wr,
  input  wire logic [7:0]           acc_wdata,
  input  wire logic                 clear_status,
  output logic [7:0]                acc_rdata,
  output logic                      acc_rvalid,
  // standard event sources, one-cycle pulses
  input  wire logic                 syntax_fault,
  input  wire logic                 run_fault,
  input  wire logic                 device_fault,
  input  wire logic                 reply_fault,
  input  wire logic                 ops_done,
  input  wire logic                 power_fail_recover,
  // unit event sources and message-available
  input  wire logic [7:0]           unit0_events,
  input  wire logic [7:0]           unit1_events,
  input  wire logic [7:0]           unit2_events,
  input  wire logic [7:0]           unit3_events,
  input  wire logic                 msg_available,
  // outputs
  output logic                      ignore_to_terminator,
  output logic                      queue_flush,
  output logic [7:0]                status_byte,
  output logic                      master_summary,
  output logic                      service_request
);
  import esr_pkg::*;

  esr_evt_if std_if ();
  esr_evt_if u_if [ESR_UNITS] ();

  logic [7:0] std_set;
  logic [7:0] unit_set [ESR_UNITS];
  logic [7:0] sre_q;
  logic [7:0] stb_d;
  logic [7:0] stb_q;
  logic [7:0] acc_rdata_q;
  logic       acc_rvalid_q;
  logic       ignore_q;
  logic       flush_q;
  logic       master_q;
  logic       srq_q;

  function automatic logic is_read_of(input esr_sel_type s, input esr_sel_type t,
                                      input logic rd);
    return rd && (s == t);
  endfunction : is_read_of

  // standard event sources; bits 6 and 1 are tied off
  always_comb begin
    std_set                   = 8'h00;
    std_set[STD_SYNTAX_FAULT] = syntax_fault;
    std_set[STD_RUN_FAULT]    = run_fault;
    std_set[STD_DEVICE_FAULT] = device_fault;
    std_set[STD_REPLY_FAULT]  = reply_fault;
    std_set[STD_OPS_DONE]     = ops_done;
    std_set[STD_POWER_UP]     = power_fail_recover;
    std_set                   = std_set & ~STD_UNUSED_MASK;
  end

  assign std_if.set     = std_set;
  assign std_if.clr     = clear_status
                          || is_read_of(acc_sel, ESR_SEL_STD_EVT, acc_rd);
  assign std_if.wr_en   = acc_wr && (acc_sel == ESR_SEL_STD_EN);
  assign std_if.wr_data = acc_wdata;

  // power-up loads the flag through the reset value
  esr_evt_reg #(.EVT_RESET(ESR_STD_PWRUP)) u_std (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .evt     (std_if)
  );

  // unit event layouts; bit positions follow the input vectors directly, except unit 1 bit 6 (AND of bits 1 and 4)
  always_comb begin
    unit_set[0] = unit0_events;
    unit_set[1] = unit1_events;
    unit_set[1][U1_BOTH_INSIDE] = unit1_events[U1_PRIMARY_INSIDE]
                                  & unit1_events[U1_SECONDARY_INSIDE];
    unit_set[2] = unit2_events;
    unit_set[3] = unit3_events;
  end

  for (genvar n = 0; n < ESR_UNITS; n++) begin : g_unit
    assign u_if[n].set     = unit_set[n];
    assign u_if[n].clr     = clear_status
                             || is_read_of(acc_sel, esr_sel_type'(4'(ESR_SEL_UNIT0 + n)),
                                           acc_rd);
    assign u_if[n].wr_en   = acc_wr && (acc_sel == esr_sel_type'(4'(ESR_SEL_UEN0 + n)));
    assign u_if[n].wr_data = acc_wdata;
    esr_evt_reg #(.EVT_RESET(ESR_EVT_RESET)) u_reg (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .evt     (u_if[n])
    );
    assign stb_d[n] = u_if[n].summary;
  end

  assign stb_d[STB_MSG_AVAIL]   = msg_available;
  assign stb_d[STB_STD_SUMMARY] = std_if.summary;
  assign stb_d[STB_MASTER]      = 1'b0;
  assign stb_d[7]               = 1'b0;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stb_q <= 8'h00;
    end else begin
      stb_q <= stb_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sre_q <= ESR_EN_RESET;
    end else if (acc_wr && acc_sel == ESR_SEL_SRE) begin
      sre_q <= acc_wdata;
    end
  end

  // master and request fire on a rising enabled bit; master holds until events clear
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      master_q <= 1'b0;
      srq_q    <= 1'b0;
    end else begin
      if (|(stb_d & ~stb_q & sre_q)) begin
        master_q <= 1'b1;
        srq_q    <= 1'b1;
      end else begin
        master_q <= |(stb_q & sre_q);
        if (is_read_of(acc_sel, ESR_SEL_STB, acc_rd)) begin
          srq_q <= 1'b0;
        end
      end
    end
  end

  // read data is the value held before any clear
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      acc_rdata_q  <= 8'h00;
      acc_rvalid_q <= 1'b0;
    end else begin
      acc_rvalid_q <= acc_rd;
      if (acc_rd) begin
        case (acc_sel)
          ESR_SEL_STB:     acc_rdata_q <= stb_q | {1'b0, master_q, 6'h00};
          ESR_SEL_SRE:     acc_rdata_q <= sre_q;
          ESR_SEL_STD_EVT: acc_rdata_q <= std_if.status;
          ESR_SEL_STD_EN:  acc_rdata_q <= std_if.enable;
          ESR_SEL_UNIT0:   acc_rdata_q <= u_if[0].status;
          ESR_SEL_UNIT1:   acc_rdata_q <= u_if[1].status;
          ESR_SEL_UNIT2:   acc_rdata_q <= u_if[2].status;
          ESR_SEL_UNIT3:   acc_rdata_q <= u_if[3].status;
          ESR_SEL_UEN0:    acc_rdata_q <= u_if[0].enable;
          ESR_SEL_UEN1:    acc_rdata_q <= u_if[1].enable;
          ESR_SEL_UEN2:    acc_rdata_q <= u_if[2].enable;
          ESR_SEL_UEN3:    acc_rdata_q <= u_if[3].enable;
          default:         acc_rdata_q <= 8'h00;
        endcase
      end
    end
  end

  // the parser must drop the rest of the message after a syntax fault
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ignore_q <= 1'b0;
      flush_q  <= 1'b0;
    end else begin
      ignore_q <= syntax_fault;
      flush_q  <= reply_fault;
    end
  end

  assign acc_rdata            = acc_rdata_q;
  assign acc_rvalid           = acc_rvalid_q;
  assign ignore_to_terminator = ignore_q;
  assign queue_flush          = flush_q;
  assign status_byte          = stb_q;
  assign master_summary       = master_q;
  assign service_request      = srq_q;

endmodule : esr_status

// file: testbench.sv
// Purpose: random and corner checks of event status reporting
// Assumes: events drawn sparse, except unit 1 events, so registers are not all ones
// Notes:   service request enable is set once, so master follows the enabled or
`timescale 1ns/1ps
module testbench;
  import esr_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rstn    = 1'b0;
  esr_sel_type acc_sel;
  logic        acc_rd, acc_wr, clear_status, acc_rvalid, mav, ign, flush, master, srq;
  logic [7:0]  acc_wdata, acc_rdata, status_byte, sre, w, last_stb;
  logic        exp_srq, last_mst;
  logic [5:0]  evp;
  logic [7:0]  uev [4];
  logic [7:0]  exp_e [5];
  logic [7:0]  en [5];
  logic [3:0]  s;
  int          seed = 32'h00ca3193, num_errors = 0, checked = 0, k;
  always #4 sys_clk = ~sys_clk;
  esr_status esr_status_inst (.sys_clk(sys_clk), .rstn(rstn), .acc_sel(acc_sel),
    .acc_rd(acc_rd), .acc_wr(acc_wr), .acc_wdata(acc_wdata), .clear_status(clear_status),
    .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid), .syntax_fault(evp[4]),
    .run_fault(evp[3]), .device_fault(evp[2]), .reply_fault(evp[1]), .ops_done(evp[0]),
    .power_fail_recover(evp[5]), .unit0_events(uev[0]), .unit1_events(uev[1]),
    .unit2_events(uev[2]), .unit3_events(uev[3]), .msg_available(mav),
    .ignore_to_terminator(ign), .queue_flush(flush), .status_byte(status_byte),
    .master_summary(master), .service_request(srq));
  esr_ctl_model esr_ctl_model_inst (.sys_clk(sys_clk), .acc_sel(acc_sel), .acc_rd(acc_rd),
    .acc_wr(acc_wr), .acc_wdata(acc_wdata), .clear_status(clear_status),
    .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid));
  function automatic logic [7:0] stb_exp();
    logic [7:0] b = {2'b00, |(exp_e[0] & en[0]), mav, 4'h0};
    for (int i = 0; i < 4; i++) b[i] = |(exp_e[i+1] & en[i+1]);
    return b;
  endfunction : stb_exp
  task automatic cmp8(input string name, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask : cmp8
  task automatic cmp1(input string name, input logic e, input logic g);
    cmp8(name, {7'h0, e}, {7'h0, g});
  endtask : cmp1
  task automatic step(input int op, input logic [3:0] sel, input logic [7:0] wd);
    logic [7:0] ev [5];
    logic [7:0] ret, got;
    int r;
    @(negedge sys_clk);
    evp = 6'($random(seed) & $random(seed) & $random(seed));
    for (int i = 0; i < 4; i++) uev[i] = 8'($random(seed) & $random(seed));
    uev[1] = 8'($random(seed));
    mav = 1'($random(seed));
    ev[0] = {evp[5], 1'b0, evp[4:1], 1'b0, evp[0]};
    ev[1] = uev[0];
    ev[2] = {uev[1][7], uev[1][1] & uev[1][4], uev[1][5:0]};
    ev[3] = uev[2];
    ev[4] = uev[3];
    r = (sel == 4'h2) ? 0 : (sel >= 4'h4 && sel <= 4'h7) ? sel - 3 : -1;
    ret = (r >= 0) ? exp_e[r] : (sel == 4'h3) ? en[0] : (sel == 4'h1) ? sre :
          (sel == 4'h0) ? (last_stb | {1'b0, last_mst, 6'h00}) : 8'h00;
    if (sel >= 4'h8 && sel <= 4'hb) ret = en[sel-7];
    fork
      case (op)
        0: esr_ctl_model_inst.rd(esr_sel_type'(sel), got);
        1: esr_ctl_model_inst.wr(esr_sel_type'(sel), wd);
        2: esr_ctl_model_inst.cls();
        default: @(negedge sys_clk);
      endcase
      begin
        @(negedge sys_clk);
        evp = '0;
        for (int i = 0; i < 4; i++) uev[i] = '0;
      end
    join
    for (int i = 0; i < 5; i++)
      exp_e[i] = (op == 2 || (op == 0 && r == i)) ? ev[i] : exp_e[i] | ev[i];
    if (op == 1 && sel == 4'h3) en[0] = wd;
    if (op == 1 && sel >= 4'h8) en[sel-7] = wd;
    if (op == 1 && sel == 4'h1) sre = wd;
    if (op == 0) cmp8("read data", ret, got);
    exp_srq = ((op == 0 && sel == 4'h0) ? 1'b0 : exp_srq) | (|(stb_exp() & ~last_stb & sre));
    // master falls one edge after the status byte, so wait one more cycle
    repeat (4) @(negedge sys_clk);
    cmp8("status byte", stb_exp(), status_byte);
    cmp1("master", |(stb_exp() & sre), master);
    cmp1("service request", exp_srq, srq);
    last_stb = stb_exp();
    last_mst = |(last_stb & sre);
  endtask : step
  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  initial begin
    {evp, mav} = '0;
    uev = '{default: 8'h00};
    repeat (2) begin
      exp_e = '{8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
      en = '{default: 8'h00};
      sre = 8'h00;
      last_stb = 8'h00;
      last_mst = 1'b0;
      exp_srq = 1'b0;
      rstn = 1'b0;
      repeat (5) @(negedge sys_clk);
      rstn = 1'b1;
      step(0, 4'h2, 8'h00);
      step(1, 4'h1, 8'h2f);
      for (int n = 0; n < 60; n++) begin
        k = {$random(seed)} % 4;
        w = 8'($random(seed));
        s = (k == 1) ? (w[2] ? 4'h3 : 4'h8 + w[1:0]) : 4'({$random(seed)} % 16);
        step(k, s, w);
      end
    end
    final_report();
  end
  initial begin
    #100000;
    num_errors++;
    final_report();
  end
endmodule : testbench
